/* File: hdl/rsf_reset_source.sv */
// Purpose: Reset cause flags, threshold select, guard registers
// Assumes: AHB-Lite slave, zero wait states, supplyLow already filtered analog
// Notes: Flags survive system resets; only nrst (power-on) or a software write clears them
//
// Functional notes
// - Flag register bits 7..4 read zero
// - Guard corruption sets flag; software clears
// - Low supply resets outside sleep, sets flag
// - Low supply must outlast qualify time
// - Low-voltage flag set; software clears only
// - Four valid threshold codes recognised
// - Bad threshold code resets, restores 55h
// - Bad threshold code sets its flag
// - Low-voltage reset keeps threshold contents
// - Low-voltage detection off in sleep/idle
// - Writing 55h to program control resets
// - Watchdog timeout in run: reset, timeout flag
// - Watchdog timeout asleep: PC/SP reset, timeout flag
// - Watchdog field corruption sets its flag
// - Guard register off its codes resets
// - Watchdog field: 15h off, 0Ah on
`include "rsf_defines.svh"
`timescale 1ns/10ps
`default_nettype none
module rsf_reset_source #(
   parameter int SRESET_CYC = (`RSF_SRESET_NS + `RSF_CLK_NS - 1) / `RSF_CLK_NS,
   parameter int LVQ_CYC = (`RSF_LVQ_NS + `RSF_CLK_NS - 1) / `RSF_CLK_NS
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic [31:0] hrdata,
   output logic hreadyout,
   output logic hresp,
   input wire logic supplyLow,
   input wire logic sleepMode,
   input wire logic wdogTimeout,
   output rsf_pkg::rsf_req_type resetReq,
   output logic wdogEnable,
   output logic timeoutStatusFlag,
   output logic [7:0] thresholdCode
);
   import rsf_pkg::*;
   // ============================================
   // Parameter check
   initial begin
      if (SRESET_CYC < 1 || LVQ_CYC < 1) begin
         $error("rsf_reset_source delays must be at least one cycle");
      end
   end
   // ============================================
   // Code check functions, used on the stored register values only
   function automatic logic thrValid(input logic [7:0] c);
      thrValid = (c == `RSF_THR_2V10) || (c == `RSF_THR_2V55) ||
                 (c == `RSF_THR_3V15) || (c == `RSF_THR_3V80);
   endfunction
   function automatic logic guardValid(input logic [7:0] c);
      guardValid = (c == `RSF_GUARD_NOP_A) || (c == `RSF_GUARD_NOP_B);
   endfunction
   function automatic logic wdogValid(input logic [4:0] c);
      wdogValid = (c == `RSF_WDOG_OFF) || (c == `RSF_WDOG_ON);
   endfunction
   // ============================================
   // Registers
   rsf_flags_type flags_reg; // Reset causes, power-on domain only
   logic [7:0] thresh_reg; // Low-voltage threshold select
   logic [7:0] guard_reg; // Reset guard register
   logic [7:0] wdogCtl_reg; // Watchdog control, enable field in 7..3
   logic timeout_reg; // Timeout status flag
   logic sysRst_reg; // Internal system reset level
   logic [1:0] supplySync_reg; // Pin synchroniser
   logic [1:0] sleepSync_reg; // Pin synchroniser
   logic [1:0] wdtSync_reg; // Pin synchroniser
   logic wdtSeen_reg; // Edge detect history
   rsf_state_type state_reg; // Reset pulse sequencer
   logic [2:0] pulse_reg; // Reset pulse length
   logic lvReset_reg; // Current pulse is a low-voltage one
   // ============================================
   // Bus address phase capture
   logic wrPend_reg; // Pending write data phase
   logic [7:0] wrAddr_reg; // Its address
   logic addrPhase;
   assign addrPhase = hsel && hready && htrans[1];
   // ============================================
   // Write decode from the pending data phase
   logic wrFlags, wrThresh, wrGuard, wrWdog, wrPm;
   assign wrFlags = wrPend_reg && (wrAddr_reg == `RSF_OFF_FLAGS);
   assign wrThresh = wrPend_reg && (wrAddr_reg == `RSF_OFF_THRESH);
   assign wrGuard = wrPend_reg && (wrAddr_reg == `RSF_OFF_GUARD);
   assign wrWdog = wrPend_reg && (wrAddr_reg == `RSF_OFF_WDOG);
   assign wrPm = wrPend_reg && (wrAddr_reg == `RSF_OFF_PMCTL);
   logic [7:0] wByte;
   assign wByte = hwdata[7:0];
   // ============================================
   // Synchronised inputs (second stage only is used)
   logic supplyLowS, sleepS, wdtS, wdtRise;
   assign supplyLowS = supplySync_reg[1];
   assign sleepS = sleepSync_reg[1];
   assign wdtS = wdtSync_reg[1];
   assign wdtRise = wdtS && !wdtSeen_reg;
   // ============================================
   // Corruption detectors
   logic thrBad, guardBad, wdogBad;
   assign thrBad = !thrValid(thresh_reg);
   assign guardBad = !guardValid(guard_reg);
   assign wdogBad = !wdogValid(wdogCtl_reg[7:3]);
   // ============================================
   // Delay counters: corruption delay and supply qualify time
   logic thrExp, guardExp, wdogExp, lvExp, lvArm;
   assign lvArm = supplyLowS && !sleepS;
   rsf_delay #(.COUNT(SRESET_CYC)) uThrDly (.clk(clk), .nrst(nrst),
      .start(thrBad), .hold(thrBad), .expire(thrExp));
   rsf_delay #(.COUNT(SRESET_CYC)) uGuardDly (.clk(clk), .nrst(nrst),
      .start(guardBad), .hold(guardBad), .expire(guardExp));
   rsf_delay #(.COUNT(SRESET_CYC)) uWdogDly (.clk(clk), .nrst(nrst),
      .start(wdogBad), .hold(wdogBad), .expire(wdogExp));
   rsf_delay #(.COUNT(LVQ_CYC)) uLvDly (.clk(clk), .nrst(nrst),
      .start(lvArm), .hold(lvArm), .expire(lvExp));
   // ============================================
   // Reset causes
   logic wdtRun, wdtSleep, pmHit, fullCause;
   assign wdtRun = wdtRise && !sleepS;
   assign wdtSleep = wdtRise && sleepS;
   assign pmHit = wrPm && (wByte == `RSF_PM_RESET_CODE);
   assign fullCause = thrExp || guardExp || wdogExp || lvExp || wdtRun || pmHit;
   // ============================================
   // Flag next value: set wins over a software clear
   rsf_flags_type flagsNext;
   rsf_flags_type flagsSet;
   assign flagsSet.rstctlCorrupt = guardExp;
   assign flagsSet.lowVoltage = lvExp;
   assign flagsSet.thresholdCorrupt = thrExp;
   assign flagsSet.wdogCorrupt = wdogExp;
   assign flagsNext = wrFlags ? (rsf_flags_type'(wByte[3:0]) | flagsSet)
                              : (flags_reg | flagsSet);
   // ============================================
   // Read mux
   logic [31:0] rdMux;
   logic [7:0] rdAddr;
   assign rdAddr = haddr[7:0];
   assign rdMux = (rdAddr == `RSF_OFF_FLAGS) ? {28'h0, flags_reg} :
                  (rdAddr == `RSF_OFF_THRESH) ? {24'h0, thresh_reg} :
                  (rdAddr == `RSF_OFF_GUARD) ? {24'h0, guard_reg} :
                  (rdAddr == `RSF_OFF_WDOG) ? {24'h0, wdogCtl_reg} :
                  (rdAddr == `RSF_OFF_STATUS) ? {31'h0, timeout_reg} :
                  32'h0;
   // ============================================
   // Bus slave: zero wait, always OKAY, read data registered
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wrPend_reg <= 1'b0;
         wrAddr_reg <= 8'h00;
         hrdata <= 32'h0;
      end else begin
         wrPend_reg <= addrPhase && hwrite;
         wrAddr_reg <= haddr[7:0];
         hrdata <= (addrPhase && !hwrite) ? rdMux : 32'h0;
      end
   end
   always_ff @(posedge clk) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
   end
   // ============================================
   // Input synchronisers
   always_ff @(posedge clk) begin
      if (!nrst) begin
         supplySync_reg <= 2'b00;
         sleepSync_reg <= 2'b00;
         wdtSync_reg <= 2'b00;
         wdtSeen_reg <= 1'b0;
      end else begin
         supplySync_reg <= {supplySync_reg[0], supplyLow};
         sleepSync_reg <= {sleepSync_reg[0], sleepMode};
         wdtSync_reg <= {wdtSync_reg[0], wdogTimeout};
         wdtSeen_reg <= wdtS;
      end
   end
   // ============================================
   // Flags: power-on reset only, never system reset
   always_ff @(posedge clk) begin
      if (!nrst) begin
         flags_reg <= '0;
      end else begin
         flags_reg <= flagsNext;
      end
   end
   // ============================================
   // Threshold select: bad code restores default; low-voltage keeps it
   always_ff @(posedge clk) begin
      if (!nrst || thrExp) begin
         thresh_reg <= `RSF_THR_2V10;
      end else if (wrThresh) begin
         thresh_reg <= wByte;
      end else if (sysRst_reg && !lvReset_reg) begin
         thresh_reg <= `RSF_THR_2V10;
      end // low-voltage pulse leaves contents alone
   end
   // ============================================
   // Guard and watchdog control: system resets restore defaults
   always_ff @(posedge clk) begin
      if (!nrst || sysRst_reg) begin
         guard_reg <= `RSF_GUARD_NOP_A;
         wdogCtl_reg <= {`RSF_WDOG_ON, 3'b011};
      end else begin
         guard_reg <= wrGuard ? wByte : guard_reg;
         wdogCtl_reg <= wrWdog ? wByte : wdogCtl_reg;
      end
   end
   // ============================================
   // Timeout status: set by watchdog, cleared by power-on
   always_ff @(posedge clk) begin
      if (!nrst) begin
         timeout_reg <= 1'b0;
      end else if (wdtRise) begin
         timeout_reg <= 1'b1;
      end
   end
   // ============================================
   // Reset pulse sequencer; also blocks new causes during the pulse
   always_ff @(posedge clk) begin
      if (!nrst) begin
         state_reg <= RSF_IDLE;
         pulse_reg <= 3'h0;
         sysRst_reg <= 1'b0;
         lvReset_reg <= 1'b0;
         resetReq <= '0;
      end else begin
         unique case (state_reg)
            RSF_IDLE: begin
               resetReq.pcSpReset <= wdtSleep;
               if (fullCause) begin
                  state_reg <= RSF_PULSE;
                  pulse_reg <= 3'(`RSF_PULSE_CYC - 1);
                  sysRst_reg <= 1'b1;
                  lvReset_reg <= lvExp && !thrExp;
                  resetReq.fullReset <= 1'b1;
               end
            end
            RSF_PULSE: begin
               resetReq.pcSpReset <= 1'b0;
               if (pulse_reg == 3'h0) begin
                  state_reg <= RSF_WAIT;
                  sysRst_reg <= 1'b0;
                  resetReq.fullReset <= 1'b0;
               end else begin
                  pulse_reg <= pulse_reg - 3'h1;
               end
            end
            RSF_WAIT: begin
               // One idle cycle lets restored registers settle
               state_reg <= RSF_IDLE;
               lvReset_reg <= 1'b0;
            end
         endcase
      end
   end
   // ============================================
   // Status outputs from flops
   always_ff @(posedge clk) begin
      if (!nrst) begin
         wdogEnable <= 1'b1;
         timeoutStatusFlag <= 1'b0;
         thresholdCode <= `RSF_THR_2V10;
      end else begin
         wdogEnable <= (wdogCtl_reg[7:3] == `RSF_WDOG_ON);
         timeoutStatusFlag <= timeout_reg;
         thresholdCode <= thresh_reg;
      end
   end
endmodule // rsf_reset_source
`default_nettype wire

/* File: shared/rsf_defines.svh */
// Purpose: Constants for the reset source flag and threshold block
// Assumes: 32-bit AHB-Lite register window, one word per register
// Notes: Offsets chosen by the block owner
`ifndef RSF_DEFINES_SVH
`define RSF_DEFINES_SVH
// ============================================
// Register byte offsets
`define RSF_OFF_FLAGS 8'h00
`define RSF_OFF_THRESH 8'h04
`define RSF_OFF_GUARD 8'h08
`define RSF_OFF_WDOG 8'h0C
`define RSF_OFF_PMCTL 8'h10
`define RSF_OFF_STATUS 8'h14
// ============================================
// Flag bit positions
`define RSF_BIT_RSTCTL 3
`define RSF_BIT_LOWV 2
`define RSF_BIT_THRESH 1
`define RSF_BIT_WDOG 0
// ============================================
// Codes and reset values
`define RSF_THR_2V10 8'h55
`define RSF_THR_2V55 8'h33
`define RSF_THR_3V15 8'h99
`define RSF_THR_3V80 8'hAA
`define RSF_GUARD_NOP_A 8'h55
`define RSF_GUARD_NOP_B 8'hAA
`define RSF_WDOG_OFF 5'h15
`define RSF_WDOG_ON 5'h0A
`define RSF_PM_RESET_CODE 8'h55
// ============================================
// Timing, in ns and cycles at 20 MHz
`define RSF_CLK_NS 50
`define RSF_SRESET_NS 200000
`define RSF_LVQ_NS 120000
`define RSF_PULSE_CYC 4
`endif

/* File: shared/rsf_pkg.sv */
// Purpose: Types for the reset source flag block
// Assumes: Constants live in rsf_defines.svh
// Notes: Structs carry grouped status and requests
package rsf_pkg;
   // ============================================
   // Recorded reset causes
   typedef struct packed {
      logic rstctlCorrupt;
      logic lowVoltage;
      logic thresholdCorrupt;
      logic wdogCorrupt;
   } rsf_flags_type;
   // Reset requests towards the core
   typedef struct packed {
      logic fullReset;
      logic pcSpReset;
   } rsf_req_type;
   // Sequencer states
   typedef enum logic [1:0] {RSF_IDLE, RSF_WAIT, RSF_PULSE} rsf_state_type;
endpackage

/* File: hdl/rsf_delay.sv */
// Purpose: Start-on-event countdown producing an expiry pulse
// Assumes: Start ignored while already running
// Notes: Used for the soft reset delay and low-voltage qualify time
`timescale 1ns/10ps
`default_nettype none
module rsf_delay #(
   parameter int COUNT = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic start,
   input wire logic hold,
   output logic expire
);
   import rsf_pkg::*;
   // ============================================
   // Parameter check
   initial begin
      if (COUNT < 1) begin
         $error("rsf_delay COUNT must be at least one");
      end
   end
   logic [31:0] cnt_reg; // Elapsed cycles
   logic run_reg; // Counting
   logic [31:0] cntLast;
   assign cntLast = 32'(COUNT - 1);
   // ============================================
   // Countdown; hold low aborts, so short episodes are dropped
   always_ff @(posedge clk) begin
      if (!nrst || !hold) begin
         cnt_reg <= 32'h0;
         run_reg <= 1'b0;
         expire <= 1'b0;
      end else if (!run_reg) begin
         run_reg <= start;
         cnt_reg <= 32'h0;
         expire <= 1'b0;
      end else begin
         expire <= (cnt_reg == cntLast);
         run_reg <= (cnt_reg != cntLast);
         cnt_reg <= cnt_reg + 32'h1;
      end
   end
endmodule // rsf_delay
`default_nettype wire

/* File: bench/rsf_reset_source_chk.sv */
// Purpose: Port assertions for the reset source block
// Assumes: Synchronous active-low nrst, one clock
// Notes: Bound into every rsf_reset_source instance
`timescale 1ns/10ps
`default_nettype none
module rsf_reset_source_chk #(
   parameter int SRESET_CYC = 4,
   parameter int LVQ_CYC = 4
) (
   input wire logic clk,
   input wire logic nrst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic [31:0] hrdata,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic wdogTimeout,
   input wire rsf_pkg::rsf_req_type resetReq,
   input wire logic wdogEnable,
   input wire logic timeoutStatusFlag,
   input wire logic [7:0] thresholdCode
);
   import rsf_pkg::*;
   // ==========================================
   // Helpers
   wire logic rdTaken = hsel & hready & htrans[1] & ~hwrite; // Read address phase taken
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);
   // Zero wait states, always OKAY
   ready_high_a: assert property (hreadyout) else $error("hreadyout low");
   resp_okay_a: assert property (!hresp) else $error("hresp not OKAY");
   // Read data only in a data phase
   rdata_idle_a: assert property (hrdata != 32'h0 |-> $past(rdTaken))
      else $error("hrdata outside data phase");
   flag_upper_a: assert property ($past(rdTaken && haddr[7:0] == 8'h00) |-> hrdata[31:4] == 28'h0)
      else $error("flag upper bits set");
   // Pulse of four, then a dead cycle
   pulse_len_a: assert property ($rose(resetReq.fullReset) |-> resetReq.fullReset[*4] ##1 !resetReq.fullReset)
      else $error("full reset length wrong");
   code_valid_a: assert property ($fell(resetReq.fullReset) |-> thresholdCode inside {8'h55, 8'h33, 8'h99, 8'hAA})
      else $error("threshold invalid after reset");
   wdog_on_a: assert property ($fell(resetReq.fullReset) |-> wdogEnable)
      else $error("watchdog not enabled after reset");
   pcsp_short_a: assert property ($rose(resetReq.pcSpReset) |=> !resetReq.pcSpReset && !resetReq.fullReset)
      else $error("pc/sp pulse wrong");
   wdt_flag_a: assert property ($rose(wdogTimeout) |-> ##[2:6] timeoutStatusFlag)
      else $error("timeout flag not set");
endmodule // rsf_reset_source_chk
bind rsf_reset_source rsf_reset_source_chk #(.SRESET_CYC(SRESET_CYC), .LVQ_CYC(LVQ_CYC)) i_chk (
   .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
   .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
   .wdogTimeout(wdogTimeout), .resetReq(resetReq), .wdogEnable(wdogEnable),
   .timeoutStatusFlag(timeoutStatusFlag), .thresholdCode(thresholdCode));
`default_nettype wire

/* File: bench/rsf_reset_source_tb.sv */
// Purpose: Self-checking bench for the reset source block
// Assumes: Short delays of 4 cycles, zero-wait bus
// Notes: Reads noted in a queue, checked by the monitor
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin nCompared++; if ((got) !== (exp)) begin mismatches++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module rsf_reset_source_tb;
   import rsf_pkg::*;
   logic clk = 1'b0, nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, rdPhase = 1'b0;
   logic [31:0] haddr = 32'h0, hwdata = 32'h0, seed = 32'd93769, expRd, b;
   logic [1:0] htrans = 2'h0;
   logic supplyLow = 1'b0, sleepMode = 1'b0, wdogTimeout = 1'b0, lastFull = 1'b0, lastPc = 1'b0;
   wire logic [31:0] hrdata;
   wire logic hready, hresp, wdogEnable, toFlag;
   wire logic [7:0] thrCode;
   rsf_req_type resetReq;
   int mismatches = 0, nCompared = 0, pulses = 0, pcsp = 0, expPulses = 0, cycles = 0;
   logic [31:0] expQ[$];
   logic [31:0] codes [4] = '{32'h55, 32'h33, 32'h99, 32'hAA};
   logic [7:0] badAddr [3] = '{8'h04, 8'h08, 8'h0C};
   logic [31:0] badFlag [3] = '{32'h2, 32'h8, 32'h1};
   rsf_reset_source #(.SRESET_CYC(4), .LVQ_CYC(4)) i_rsf_reset_source (
      .clk(clk), .nrst(nrst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
      .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hready),
      .hresp(hresp), .supplyLow(supplyLow), .sleepMode(sleepMode), .wdogTimeout(wdogTimeout),
      .resetReq(resetReq), .wdogEnable(wdogEnable), .timeoutStatusFlag(toFlag),
      .thresholdCode(thrCode));
   initial begin
      forever #25 clk = ~clk;
   end
   // ==========================================
   // Monitor: read data, reset pulses, hang guard
   always @(posedge clk) begin
      cycles++;
      if (rdPhase) begin
         expRd = expQ.pop_front();
         `CHK("hrdata", expRd, hrdata)
         `CHK("hresp", 1'b0, hresp)
      end
      if (resetReq.fullReset && !lastFull) pulses++;
      if (resetReq.pcSpReset && !lastPc) pcsp++;
      lastFull = resetReq.fullReset;
      lastPc = resetReq.pcSpReset;
      if (cycles > 5000) begin
         mismatches++;
         conclude();
      end
   end
   function automatic logic [31:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed;
   endfunction
   // Random code that the target register stores but its check treats as corrupt
   function automatic logic [31:0] badFor(input logic [7:0] a);
      logic [31:0] v;
      do v = rnd() & 32'hFF;
      while ((a == 8'h04 && v[7:0] inside {8'h55, 8'h33, 8'h99, 8'hAA}) ||
             (a == 8'h08 && v[7:0] inside {8'h55, 8'hAA}) ||
             (a == 8'h0C && v[7:3] inside {5'h15, 5'h0A}));
      return v;
   endfunction
   // Single AHB-Lite transfer, held until hready
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      hsel <= 1'b1; htrans <= 2'b10; hwrite <= wr; haddr <= {24'h0, a};
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0; htrans <= 2'b00; hwdata <= d; rdPhase <= !wr;
      do @(posedge clk); while (hready !== 1'b1);
      rdPhase <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      bus(1'b0, a, 32'h0);
   endtask
   task automatic idle(input int n);
      repeat (n) @(posedge clk);
   endtask
   // Long enough for delay, pulse and dead cycle
   task automatic pulsesAre(input int add);
      expPulses += add;
      idle(30);
      `CHK("pulses", expPulses, pulses)
   endtask
   task automatic lowFor(input int n);
      supplyLow <= 1'b1;
      idle(n);
      supplyLow <= 1'b0;
   endtask
   task automatic conclude();
      if (mismatches == 0 && nCompared > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      repeat (16) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rd(8'h00, 32'h0);
      rd(8'h04, 32'h55);
      rd(8'h08, 32'h55);
      rd(8'h0C, 32'h53);
      rd(8'h20, 32'h0);
      `CHK("thresholdCode", 8'h55, thrCode)
      `CHK("toFlag", 1'b0, toFlag)
      foreach (codes[i]) begin
         bus(1'b1, 8'h04, codes[i]);
         rd(8'h04, codes[i]);
      end
      bus(1'b1, 8'h08, 32'hAA);
      bus(1'b1, 8'h10, 32'h54);
      bus(1'b1, 8'h0C, 32'hA8);
      idle(2);
      `CHK("wdogEnable", 1'b0, wdogEnable)
      bus(1'b1, 8'h0C, 32'h50);
      pulsesAre(0);
      `CHK("wdogEnable", 1'b1, wdogEnable)
      // Corrupt each guarded register in turn
      foreach (badAddr[i]) begin
         bus(1'b1, 8'h04, 32'h33);
         b = badFor(badAddr[i]);
         bus(1'b1, badAddr[i], b);
         pulsesAre(1);
         rd(8'h00, badFlag[i]);
         rd(8'h04, 32'h55);
         rd(8'h08, 32'h55);
         bus(1'b1, 8'h00, 32'h0);
         rd(8'h00, 32'h0);
      end
      bus(1'b1, 8'h00, 32'hFF);
      rd(8'h00, 32'h0F);
      bus(1'b1, 8'h00, 32'h0);
      bus(1'b1, 8'h10, 32'h55);
      pulsesAre(1);
      // Low supply: short lows ignored, long one resets
      bus(1'b1, 8'h04, 32'h99);
      repeat (4) begin
         lowFor(1 + int'(rnd() % 3));
         idle(6);
      end
      pulsesAre(0);
      lowFor(9);
      pulsesAre(1);
      rd(8'h00, 32'h4);
      rd(8'h04, 32'h99);
      bus(1'b1, 8'h00, 32'h0);
      sleepMode <= 1'b1;
      idle(4);
      lowFor(20);
      pulsesAre(0);
      wdogTimeout <= 1'b1;
      idle(3);
      wdogTimeout <= 1'b0;
      pulsesAre(0);
      `CHK("pcsp", 1, pcsp)
      `CHK("toFlag", 1'b1, toFlag)
      rd(8'h14, 32'h1);
      rd(8'h04, 32'h99);
      sleepMode <= 1'b0;
      idle(4);
      wdogTimeout <= 1'b1;
      idle(3);
      wdogTimeout <= 1'b0;
      pulsesAre(1);
      rd(8'h04, 32'h55);
      idle(2);
      conclude();
   end
endmodule // rsf_reset_source_tb
`default_nettype wire
